// *** logic/serial_adc_frame_receiver.sv ***
`timescale 1ns/100ps
module serial_adc_frame_receiver #(
	parameter int unsigned WORD_W = adc_rx_pkg::WORD_W,
	parameter int unsigned DIV_W  = adc_rx_pkg::DIV_W,
	parameter int unsigned PER_W  = adc_rx_pkg::PER_W
) (
	input  wire logic                            clock_i,
	input  wire logic                            reset_n_i,
	input  wire logic [adc_rx_pkg::ADDR_W-1:0]   addr_i,
	input  wire logic [adc_rx_pkg::DATA_W-1:0]   wr_data_i,
	input  wire logic                            wr_i,
	input  wire logic                            rd_i,
	output logic      [adc_rx_pkg::DATA_W-1:0]   rd_data_o,
	input  wire logic                            host_receive_data_i,
	output logic                                 host_receive_clock_o,
	output logic                                 host_receive_frame_o,
	output logic                                 irq_o
);

	localparam int unsigned DW = adc_rx_pkg::DATA_W;
	localparam int unsigned EW = adc_rx_pkg::EVT_W;
	localparam logic [PER_W-1:0] FIRST_BIT = PER_W'(adc_rx_pkg::FIRST_DATA_BIT);
	localparam logic [PER_W-1:0] LAST_BIT  = PER_W'(adc_rx_pkg::FIRST_DATA_BIT + WORD_W - 1);
	localparam logic [PER_W-1:0] SYNC_BIT  = PER_W'(adc_rx_pkg::FRAME_BIT);

	////////////////////////////////////////////////////////////////////////////////
	// register state

	logic [adc_rx_pkg::CTRL_W-1:0] ctrl_r;
	logic [DIV_W-1:0]              div_r;
	logic [PER_W-1:0]              per_r;
	logic [EW-1:0]                 mask_r;
	logic [EW-1:0]                 status_r;
	logic                          rdy_r;
	logic [WORD_W-1:0]             rx_data_r;

	logic enable;
	logic wr_ctrl;
	logic rd_data_hit;
	logic rd_status_hit;

	assign enable        = ctrl_r[adc_rx_pkg::CTRL_EN_BIT];
	assign wr_ctrl       = wr_i && (addr_i == adc_rx_pkg::ADDR_CTRL);
	assign rd_data_hit   = rd_i && (addr_i == adc_rx_pkg::ADDR_DATA);
	assign rd_status_hit = rd_i && (addr_i == adc_rx_pkg::ADDR_STATUS);

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ctrl_r <= adc_rx_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= wr_data_i[adc_rx_pkg::CTRL_W-1:0];
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			div_r <= DIV_W'(adc_rx_pkg::DIV_RST);
			per_r <= PER_W'(adc_rx_pkg::PERIOD_RST);
			mask_r <= adc_rx_pkg::MASK_RST;
		end else if (wr_i) begin
			unique case (addr_i)
				adc_rx_pkg::ADDR_DIV: begin
					div_r <= wr_data_i[DIV_W-1:0];
				end
				adc_rx_pkg::ADDR_PERIOD: begin
					per_r <= wr_data_i[PER_W-1:0];
				end
				adc_rx_pkg::ADDR_MASK: begin
					mask_r <= wr_data_i[EW-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// data pin synchroniser

	logic [1:0] data_sync_r;
	logic       data_in;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_sync_r <= 2'h0;
		end else begin
			data_sync_r <= {data_sync_r[0], host_receive_data_i};
		end
	end

	assign data_in = data_sync_r[1];

	////////////////////////////////////////////////////////////////////////////////
	// sample-rate generator

	logic                gen_cnt_r;
	logic                gen_tick;
	logic [DIV_W-1:0]    tick_cnt_r;
	logic [DIV_W:0]      half_pt;
	logic                rise_evt;
	logic                fall_evt;

	// generator input is half the processor clock
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gen_cnt_r <= 1'b0;
		end else if (!enable) begin
			gen_cnt_r <= 1'b0;
		end else begin
			gen_cnt_r <= ~gen_cnt_r;
		end
	end

	assign gen_tick = enable && (gen_cnt_r == adc_rx_pkg::GEN_LAST);

	// bit period is divider plus one generator ticks
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_cnt_r <= '0;
		end else if (!enable) begin
			tick_cnt_r <= div_r;
		end else if (gen_tick) begin
			if (tick_cnt_r >= div_r) begin
				tick_cnt_r <= '0;
			end else begin
				tick_cnt_r <= tick_cnt_r + DIV_W'(1);
			end
		end
	end

	// high for the first half; divider must be at least one
	assign half_pt  = ({1'b0, div_r} + (DIV_W+1)'(1)) >> 1;
	assign rise_evt = gen_tick && (tick_cnt_r >= div_r);
	assign fall_evt = gen_tick && ({1'b0, tick_cnt_r} + (DIV_W+1)'(1) == half_pt);

	////////////////////////////////////////////////////////////////////////////////
	// bit counter, clock and frame outputs

	logic [PER_W-1:0] bit_cnt_r;
	logic [PER_W-1:0] bit_cnt_nxt;

	always_comb begin
		if (bit_cnt_r >= per_r) begin
			bit_cnt_nxt = '0;
		end else begin
			bit_cnt_nxt = bit_cnt_r + PER_W'(1);
		end
	end

	// parked at the last bit so the first edge opens a frame
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bit_cnt_r <= '0;
		end else if (!enable) begin
			bit_cnt_r <= per_r;
		end else if (rise_evt) begin
			bit_cnt_r <= bit_cnt_nxt;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			host_receive_clock_o <= 1'b0;
		end else if (!enable) begin
			host_receive_clock_o <= 1'b0;
		end else if (rise_evt) begin
			host_receive_clock_o <= 1'b1;
		end else if (fall_evt) begin
			host_receive_clock_o <= 1'b0;
		end
	end

	// free-running frames, never an external sync
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			host_receive_frame_o <= 1'b0;
		end else if (!enable) begin
			host_receive_frame_o <= 1'b0;
		end else if (rise_evt) begin
			host_receive_frame_o <= (bit_cnt_nxt == SYNC_BIT);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// receive shifter

	logic [WORD_W-1:0] shift_r;
	logic              in_word;
	logic              word_evt;

	assign in_word  = (bit_cnt_r >= FIRST_BIT) && (bit_cnt_r <= LAST_BIT);
	assign word_evt = enable && fall_evt && (bit_cnt_r == LAST_BIT);

	// converter moves data on the rising edge; sample at the falling one
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			shift_r <= '0;
		end else if (enable && fall_evt && in_word) begin
			shift_r <= {shift_r[WORD_W-2:0], data_in};
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_data_r <= '0;
		end else if (word_evt) begin
			rx_data_r <= {shift_r[WORD_W-2:0], data_in};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// ready flag, events and interrupt

	logic overrun_evt;

	assign overrun_evt = word_evt && rdy_r && !rd_data_hit;

	// set wins over the read that clears it
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdy_r <= 1'b0;
		end else if (word_evt) begin
			rdy_r <= 1'b1;
		end else if (rd_data_hit) begin
			rdy_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			status_r <= '0;
		end else begin
			status_r[adc_rx_pkg::ST_WORD_BIT] <= word_evt ||
				(status_r[adc_rx_pkg::ST_WORD_BIT] && !rd_status_hit);
			status_r[adc_rx_pkg::ST_OVR_BIT] <= overrun_evt ||
				(status_r[adc_rx_pkg::ST_OVR_BIT] && !rd_status_hit);
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= enable && ctrl_r[adc_rx_pkg::CTRL_IRQ_BIT] && |(status_r & mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe

	logic [DW-1:0] rd_nxt;

	always_comb begin
		rd_nxt = '0;
		unique case (addr_i)
			adc_rx_pkg::ADDR_CTRL: begin
				rd_nxt = DW'(ctrl_r);
			end
			adc_rx_pkg::ADDR_DIV: begin
				rd_nxt = DW'(div_r);
			end
			adc_rx_pkg::ADDR_PERIOD: begin
				rd_nxt = DW'(per_r);
			end
			adc_rx_pkg::ADDR_DATA: begin
				rd_nxt = DW'(rx_data_r);
			end
			adc_rx_pkg::ADDR_STATUS: begin
				rd_nxt = DW'(status_r);
				rd_nxt[adc_rx_pkg::ST_RDY_BIT] = rdy_r;
			end
			adc_rx_pkg::ADDR_MASK: begin
				rd_nxt = DW'(mask_r);
			end
			default: begin
				rd_nxt = '0;
			end
		endcase
	end

	// unmapped addresses read zero; data only in the cycle after rd_i
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= '0;
		end else if (rd_i) begin
			rd_data_o <= rd_nxt;
		end else begin
			rd_data_o <= '0;
		end
	end

endmodule : serial_adc_frame_receiver

// *** logic/adc_rx_pkg.sv ***
// Behaviour
// - port runs in continuous framed mode; there is no clock-stop mode.
// - port drives both frame sync and bit clock out to the converter.
// - each sample is a 16-bit word; first data bit one bit after frame sync.
// - frame sync comes from the internal sample-rate generator only.
// - full-speed targets are a 15 MHz bit clock and 200 kHz frame rate.
// - generator input clock is half the processor clock.
// - bit clock is generator input over divider field plus one; default 4.
// - frame period field holds period minus one; 74 gives 75 bit clocks.
// - a received word raises an interrupt; software waits for ready, reads word.
// - port runs once enabled; its receive interrupt also needs the control irq bit and mask bit 0, which resets to 0.
package adc_rx_pkg;

	localparam int unsigned ADDR_W         = 3;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned WORD_W         = 16;
	localparam int unsigned DIV_W          = 8;
	localparam int unsigned PER_W          = 12;

	////////////////////////////////////////////////////////////////////////////////
	// register map, word addresses
	localparam logic [2:0]  ADDR_CTRL      = 3'h0;
	localparam logic [2:0]  ADDR_DIV       = 3'h1;
	localparam logic [2:0]  ADDR_PERIOD    = 3'h2;
	localparam logic [2:0]  ADDR_DATA      = 3'h3;
	localparam logic [2:0]  ADDR_STATUS    = 3'h4;
	localparam logic [2:0]  ADDR_MASK      = 3'h5;

	// control bits
	localparam int unsigned CTRL_EN_BIT    = 0;
	localparam int unsigned CTRL_IRQ_BIT   = 1;
	localparam int unsigned CTRL_W         = 2;

	// status bits: sticky events low, ready level above them
	localparam int unsigned ST_WORD_BIT    = 0;
	localparam int unsigned ST_OVR_BIT     = 1;
	localparam int unsigned ST_RDY_BIT     = 2;
	localparam int unsigned EVT_W          = 2;

	// reset values
	localparam logic [7:0]  DIV_RST        = 8'h04;
	localparam logic [11:0] PERIOD_RST     = 12'h04a;
	localparam logic [1:0]  CTRL_RST       = 2'h0;
	localparam logic [1:0]  MASK_RST       = 2'h0;

	// framing: sync on bit 0, data starts one bit later
	localparam int unsigned FRAME_BIT      = 0;
	localparam int unsigned FIRST_DATA_BIT = 1;

	// generator input runs at half the processor clock
	localparam logic        GEN_LAST       = 1'b1;

	// nominal rates, informational
	localparam int unsigned CLOCK_HZ       = 40_000_000;
	localparam int unsigned BIT_CLOCK_HZ   = 15_000_000;
	localparam int unsigned FRAME_HZ       = 200_000;

endpackage : adc_rx_pkg

// *** verification/adc_rx_checker_sva.sv ***
`timescale 1ns/100ps
module adc_rx_checker (
	input  wire logic        clock_i,
	input  wire logic        reset_n_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [15:0] wr_data_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [15:0] rd_data_o,
	input  wire logic        host_receive_data_i,
	input  wire logic        host_receive_clock_o,
	input  wire logic        host_receive_frame_o,
	input  wire logic        irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	logic [1:0] ctrl_r;
	logic [9:0] gap_r;
	logic       seen_r;
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			ctrl_r <= 2'h0;
		else if (wr_i && addr_i == adc_rx_pkg::ADDR_CTRL)
			ctrl_r <= wr_data_i[1:0];
	end
	// spacing check disarmed on disable until the next frame, since the generator restarts too
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			seen_r <= 1'b0;
		else if (!ctrl_r[0])
			seen_r <= 1'b0;
		else if ($rose(host_receive_frame_o))
			seen_r <= 1'b1;
	end
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i)
			gap_r <= 10'h000;
		else if ($rose(host_receive_frame_o))
			gap_r <= 10'h001;
		else if (gap_r != 10'h3ff)
			gap_r <= gap_r + 10'h001;
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_ckh;
		disable iff (!reset_n_i || !ctrl_r[0])
		$rose(host_receive_clock_o) |-> host_receive_clock_o [*4] ##1 !host_receive_clock_o;
	endproperty
	a_ckh: assert property (p_ckh) else $error("bit clock high time");
	property p_ckl;
		disable iff (!reset_n_i || !ctrl_r[0])
		$fell(host_receive_clock_o) |-> !host_receive_clock_o [*6] ##1 host_receive_clock_o;
	endproperty
	a_ckl: assert property (p_ckl) else $error("bit clock low time");
	property p_frw;
		disable iff (!reset_n_i || !ctrl_r[0])
		$rose(host_receive_frame_o) |-> host_receive_frame_o [*8] ##1 host_receive_frame_o ##1
			host_receive_frame_o ##1 !host_receive_frame_o;
	endproperty
	a_frw: assert property (p_frw) else $error("frame width");
	property p_frp;
		seen_r && $rose(host_receive_frame_o) |-> gap_r == 10'd750;
	endproperty
	a_frp: assert property (p_frp) else $error("frame spacing");
	property p_rdz;
		!$past(rd_i) |-> rd_data_o == 16'h0000;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside slot");
	property p_irq;
		irq_o |-> $past(ctrl_r) == 2'h3;
	endproperty
	a_irq: assert property (p_irq) else $error("irq while disabled");
	property p_clr;
		rd_i && addr_i == adc_rx_pkg::ADDR_STATUS && irq_o |-> ##2 !irq_o;
	endproperty
	a_clr: assert property (p_clr) else $error("irq after status read");
	property p_off;
		!ctrl_r[0] && !$past(ctrl_r[0]) |-> !host_receive_clock_o && !host_receive_frame_o;
	endproperty
	a_off: assert property (p_off) else $error("link active while off");
endmodule : adc_rx_checker

// *** verification/adc_model.sv ***
`timescale 1ns/100ps
module adc_model (
	input  wire logic        sclk_i,
	input  wire logic        frame_i,
	input  wire logic [15:0] word_i,
	output logic             sdo_o
);
	logic [15:0] sh = 16'h0000;
	int          cnt = 0;
	initial sdo_o = 1'b0;
	// chip select held active: only converter on the lines
	// sync sampled mid-bit: frame and clock rise together, so a rising-edge look would race
	always @(negedge sclk_i) begin
		if (frame_i) begin
			sh = word_i;
			cnt = 16; // first bit one bit after sync
		end
	end
	always @(posedge sclk_i) begin
		if (cnt > 0) begin
			sdo_o <= sh[cnt-1]; // msb first, changes on rising edge
			cnt--;
		end else begin
			sdo_o <= ~sdo_o; // idle line wanders so stale bits never match
		end
	end
endmodule : adc_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
	logic        clock_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic [2:0]  addr_i = 3'h0;
	logic [15:0] wr_data_i = 16'h0000;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic        pend = 1'b0;
	logic [15:0] rd_data_o;
	logic        converter_serial_out;
	logic        sclk;
	logic        frame;
	logic        irq_o;
	logic [15:0] word;
	logic [15:0] last;
	logic [15:0] exp_q[$];
	logic [15:0] ring [1024];
	int          ring_idx = 0;
	logic [2:0]  pend_a = 3'h0;
	int          seed = 32'hdda1a4ba;
	int          n_fail = 0;
	int          n_tests = 0;
	always #12.5 clock_i = ~clock_i;
	serial_adc_frame_receiver i_dut (.clock_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
		.host_receive_data_i(converter_serial_out), .host_receive_clock_o(sclk), .host_receive_frame_o(frame), .irq_o);
	adc_model i_adc (.sclk_i(sclk), .frame_i(frame), .word_i(word), .sdo_o(converter_serial_out));
	////////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic wr(logic [2:0] a, logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wr_data_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(logic [2:0] a, logic [15:0] e);
		exp_q.push_back(e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
	endtask : rd
	task automatic wait_irq;
		int k;
		for (k = 0; k < 1600 && irq_o !== 1'b1; k++)
			@(posedge clock_i);
		if (k == 1600) begin
			n_fail++;
			results();
		end
	endtask : wait_irq
	////////////////////////////////////////////////////////////////////////////////
	// word latched by the converter at sync; new random one for the next frame
	always @(negedge frame) begin
		last = word;
		word = 16'($random(seed));
	end
	always @(posedge clock_i) pend <= rd_i;
	always @(posedge clock_i) pend_a <= addr_i;
	// handler ring: each data word stored, index wraps at the end
	always @(negedge clock_i) begin
		if (pend) begin
			chk("rd_data", exp_q.pop_front(), rd_data_o);
			if (pend_a == adc_rx_pkg::ADDR_DATA) begin
				ring[ring_idx] = rd_data_o;
				ring_idx = (ring_idx + 1) % 1024;
			end
		end
	end
	initial begin
		word = 16'($random(seed));
		repeat (2) @(posedge clock_i);
		reset_n_i <= 1'b1;
		wr(3'h6, 16'($random(seed)));
		for (int a = 0; a < 8; a++)
			rd(a[2:0], a == 1 ? 16'h0004 : a == 2 ? 16'h004a : 16'h0000);
		$display("test reset done");
		wr(adc_rx_pkg::ADDR_MASK, 16'h0001);
		wr(adc_rx_pkg::ADDR_CTRL, 16'h0003);
		repeat (3) begin
			wait_irq();
			rd(adc_rx_pkg::ADDR_STATUS, 16'h0005);
			rd(adc_rx_pkg::ADDR_DATA, last);
			rd(adc_rx_pkg::ADDR_STATUS, 16'h0000);
		end
		$display("test words done");
		wait_irq();
		repeat (760) @(posedge clock_i);
		rd(adc_rx_pkg::ADDR_STATUS, 16'h0007);
		rd(adc_rx_pkg::ADDR_DATA, last);
		$display("test overrun done");
		wr(adc_rx_pkg::ADDR_MASK, 16'h0002);
		repeat (760) @(posedge clock_i);
		chk("irq", 16'h0000, {15'h0000, irq_o});
		rd(adc_rx_pkg::ADDR_STATUS, 16'h0005);
		wr(adc_rx_pkg::ADDR_CTRL, 16'h0000);
		repeat (40) @(posedge clock_i);
		chk("clock", 16'h0000, {15'h0000, sclk});
		$display("test mask done");
		results();
	end
endmodule : tb_top
bind serial_adc_frame_receiver adc_rx_checker i_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
	.wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .host_receive_data_i(host_receive_data_i),
	.host_receive_clock_o(host_receive_clock_o), .host_receive_frame_o(host_receive_frame_o), .irq_o(irq_o));
